// ---- hdl/auto_reclose_sequencer.sv ----
// Breaker auto-reclose sequencer with AHB-Lite settings and status registers.
// How it works
// - Each request line enables any shot subset.
// - Later first shot uses previous discrimination time.
// - Critical request aborts running sequence; else ignored.
// - Critical accepted only in dead/discrimination time.
// - Start delay done sets first shot active.
// - Successful shot stays active until reclaim ends.
// - Failed shot hands active flag to next.
// - Running marks dead time only.
// - Five final trips; only the cause's one.
// - Final trip indication lasts half second.
// - Reclose block input withholds only closing.
// - Open command until breaker open, then dead.
// - Close command until breaker closed, then discrimination.
// - Fault persisting after discrimination reopens, next shot.
// - Cleared fault runs reclaim, then idle shot one.
// - Line one highest priority on simultaneous expiry.
// - Critical in discrimination locks until manual close.
// - Blocked shots skipped; none left means final.
// - Manual close enters reclaim, ignoring requests.
//
// The AHB-Lite interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "ar_consts.svh"
module auto_reclose_sequencer #(
  parameter int TICK_CYCLES = `TICK_PERIOD_NS / `CLOCK_PERIOD_NS,
  parameter int TW = 16
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [3:0] requestLine,
  input wire logic criticalRequest,
  input wire logic breakerClosed,
  input wire logic [4:0] shotBlock,
  input wire logic recloseBlock,
  output var ar_pkg::breaker_cmd_t breakerCmd,
  output var ar_pkg::indication_t indication
);
  localparam int HOLD_TICKS = `FINAL_TRIP_HOLD_NS / `TICK_PERIOD_NS;
  localparam logic [2:0] NONE = 3'h5;

  typedef struct packed {
    logic [6:0] ctrl;
    logic [19:0] shotEn;
    logic [TW-1:0] reclaim;
    logic [3:0][TW-1:0] startDly;
    logic [4:0][TW-1:0] dead;
    logic [19:0][TW-1:0] discr;
    logic wrPend;
    logic [7:0] wrIdx;
    logic [31:0] rdata;
    ar_pkg::seq_state_t state;
    logic [2:0] shot;
    logic [1:0] line;
    logic manual;
    logic tripDone;
    logic cbPrev;
    logic [TW-1:0] timer;
    logic [3:0][TW-1:0] startCnt;
    logic [4:0][9:0] holdCnt;
    ar_pkg::breaker_cmd_t cmd;
    ar_pkg::indication_t ind;
  } seq_t;

  seq_t s;
  seq_t next_s;
  logic tick;
  logic [11:0] pins;
  logic [3:0] req;
  logic crit;
  logic cbClosed;
  logic [4:0] blk;
  logic rcb;

  tick_divider #(.CYCLES(TICK_CYCLES)) divider (
    .clock(clock),
    .rst(rst),
    .tick(tick)
  );

  // Every pin is foreign to this clock, so each passes two flip-flops.
  pin_sync #(.W(12)) syncPins (
    .clock(clock),
    .rst(rst),
    .pinIn({recloseBlock, shotBlock, breakerClosed, criticalRequest, requestLine}),
    .pinOut(pins)
  );
  assign {rcb, blk, cbClosed, crit, req} = pins;

  // Lowest enabled, unblocked shot of a line at or after a given shot.
  function automatic logic [2:0] firstShot(input logic [1:0] ln, input logic [2:0] from);
    logic [2:0] found;
    found = NONE;
    for (int k = 4; k >= 0; k--) begin
      if (3'(k) >= from && s.shotEn[int'(ln) * 5 + k]
          && !(s.ctrl[`CTRL_SHOT_BLOCK_LSB + k] && blk[k])) begin
        found = 3'(k);
      end
    end
    return found;
  endfunction

  // Start delay of a line: its own delay, or the previous shot's discrimination time.
  function automatic logic [TW-1:0] startTarget(input logic [1:0] ln);
    logic [2:0] f;
    f = firstShot(ln, 3'h0);
    if (f == 3'h0 || f == NONE) begin
      return s.startDly[ln];
    end
    return s.discr[(int'(f) - 1) * 4 + int'(ln)];
  endfunction

  // Highest-priority line among a set.
  function automatic logic [1:0] pickLine(input logic [3:0] set);
    logic [1:0] p;
    p = 2'h0;
    for (int k = 3; k >= 0; k--) begin
      if (set[k]) begin
        p = 2'(k);
      end
    end
    return p;
  endfunction

  // Register read multiplexer; unmapped words read as zero.
  function automatic logic [31:0] readReg(input logic [7:0] idx);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (idx == 8'(`OFS_CTRL >> 2)) v = 32'(s.ctrl);
    if (idx == 8'(`OFS_SHOT_EN >> 2)) v = 32'(s.shotEn);
    if (idx == 8'(`OFS_RECLAIM >> 2)) v = 32'(s.reclaim);
    if (idx == 8'(`OFS_STATUS >> 2)) begin
      v[`STAT_STATE_LSB +: 3] = s.state;
      v[`STAT_SHOT_ACTIVE_LSB +: 5] = s.ind.shotActive;
      v[`STAT_RUNNING_BIT] = s.ind.running;
      v[`STAT_FINAL_LSB +: 5] = s.ind.finalTrip;
      v[`STAT_OPEN_BIT] = s.cmd.openCmd;
      v[`STAT_CLOSE_BIT] = s.cmd.closeCmd;
      v[`STAT_SHOT_LSB +: 3] = s.shot;
      v[`STAT_MANUAL_BIT] = s.manual;
    end
    for (int k = 0; k < 4; k++) begin
      if (idx == 8'((`OFS_START_BASE >> 2) + k)) v = 32'(s.startDly[k]);
    end
    for (int k = 0; k < 5; k++) begin
      if (idx == 8'((`OFS_DEAD_BASE >> 2) + k)) v = 32'(s.dead[k]);
    end
    for (int k = 0; k < 20; k++) begin
      if (idx == 8'((`OFS_DISCR_BASE >> 2) + k)) v = 32'(s.discr[k]);
    end
    return v;
  endfunction

  // Whole next-state computation: bus slave, timers, sequence and outputs.
  always_comb begin
    logic [3:0] expired;
    logic [2:0] nx;
    logic [1:0] ln;
    logic trip;
    logic [2:0] tripCause;
    next_s = s;
    expired = 4'h0;
    nx = NONE;
    ln = 2'h0;
    trip = 1'b0;
    tripCause = 3'h0;

    // Bus data phase of a write, then capture of a new address phase.
    next_s.wrPend = 1'b0;
    if (s.wrPend) begin
      if (s.wrIdx == 8'(`OFS_CTRL >> 2)) next_s.ctrl = hwdata[6:0];
      if (s.wrIdx == 8'(`OFS_SHOT_EN >> 2)) next_s.shotEn = hwdata[19:0];
      if (s.wrIdx == 8'(`OFS_RECLAIM >> 2)) next_s.reclaim = hwdata[TW-1:0];
      for (int k = 0; k < 4; k++) begin
        if (s.wrIdx == 8'((`OFS_START_BASE >> 2) + k)) next_s.startDly[k] = hwdata[TW-1:0];
      end
      for (int k = 0; k < 5; k++) begin
        if (s.wrIdx == 8'((`OFS_DEAD_BASE >> 2) + k)) next_s.dead[k] = hwdata[TW-1:0];
      end
      for (int k = 0; k < 20; k++) begin
        if (s.wrIdx == 8'((`OFS_DISCR_BASE >> 2) + k)) next_s.discr[k] = hwdata[TW-1:0];
      end
    end
    if (hsel && hready && htrans[1]) begin
      next_s.wrPend = hwrite;
      next_s.wrIdx = haddr[9:2];
      next_s.rdata = readReg(haddr[9:2]);
    end

    // Shared sequence timer advances on the common tick.
    if (tick && s.timer != {TW{1'b1}}) begin
      next_s.timer = s.timer + TW'(1);
    end
    next_s.cbPrev = cbClosed;

    // Per-line start delay counters run only while waiting in idle.
    for (int k = 0; k < 4; k++) begin
      if (s.state != ar_pkg::IDLE || !req[k] || !s.ctrl[`CTRL_ENABLE_BIT]) begin
        next_s.startCnt[k] = '0;
      end else if (s.startCnt[k] >= startTarget(2'(k))) begin
        expired[k] = 1'b1;
      end else if (tick) begin
        next_s.startCnt[k] = s.startCnt[k] + TW'(1);
      end
    end

    case (s.state)
      ar_pkg::IDLE: begin
        // The synchroniser clears to zero, so a closed breaker looks like a close edge
        // after reset; settings clear too, so gating on enable hides that false edge.
        if (s.ctrl[`CTRL_ENABLE_BIT] && cbClosed && !s.cbPrev) begin
          next_s.state = ar_pkg::RECLAIM;
          next_s.manual = 1'b1;
          next_s.timer = '0;
        end else if (|expired) begin
          ln = pickLine(expired);
          nx = firstShot(ln, 3'h0);
          next_s.line = ln;
          next_s.startCnt = '0;
          next_s.timer = '0;
          if (nx == NONE) begin
            trip = 1'b1;
            tripCause = 3'(ln);
          end else begin
            next_s.shot = nx;
            next_s.state = cbClosed ? ar_pkg::OPEN : ar_pkg::DEAD;
          end
        end
      end
      ar_pkg::OPEN: begin
        if (!cbClosed) begin
          next_s.state = ar_pkg::DEAD;
          next_s.timer = '0;
        end
      end
      ar_pkg::DEAD: begin
        if (crit) begin
          trip = 1'b1;
          tripCause = 3'h4;
        end else if (s.timer >= s.dead[s.shot]) begin
          next_s.state = ar_pkg::CLOSE;
        end
      end
      ar_pkg::CLOSE: begin
        if (cbClosed) begin
          next_s.state = ar_pkg::DISCR;
          next_s.timer = '0;
        end
      end
      ar_pkg::DISCR: begin
        if (crit) begin
          trip = 1'b1;
          tripCause = 3'h4;
        end else if (s.timer >= s.discr[int'(s.shot) * 4 + int'(s.line)]) begin
          next_s.timer = '0;
          if (req[s.line]) begin
            nx = firstShot(s.line, s.shot + 3'h1);
            if (nx == NONE) begin
              trip = 1'b1;
              tripCause = 3'(s.line);
            end else begin
              next_s.shot = nx;
              next_s.state = ar_pkg::OPEN;
            end
          end else begin
            next_s.state = ar_pkg::RECLAIM;
          end
        end
      end
      ar_pkg::RECLAIM: begin
        if (!s.manual && (|req)) begin
          ln = pickLine(req);
          nx = firstShot(ln, s.shot + 3'h1);
          next_s.line = ln;
          next_s.timer = '0;
          if (nx == NONE) begin
            trip = 1'b1;
            tripCause = 3'(ln);
          end else begin
            next_s.shot = nx;
            next_s.state = ar_pkg::OPEN;
          end
        end else if (s.timer >= s.reclaim) begin
          next_s.state = ar_pkg::IDLE;
          next_s.shot = 3'h0;
          next_s.manual = 1'b0;
        end
      end
      ar_pkg::LOCK: begin
        if (!cbClosed) begin
          next_s.tripDone = 1'b1;
        end
        if (s.tripDone && cbClosed && !s.cbPrev) begin
          next_s.state = ar_pkg::RECLAIM;
          next_s.manual = 1'b1;
          next_s.timer = '0;
        end
      end
      default: begin
        next_s.state = ar_pkg::IDLE;
      end
    endcase

    // Final trip holds each cause flag for its fixed time, then it self-clears.
    for (int k = 0; k < 5; k++) begin
      if (tick && s.holdCnt[k] != 10'h000) begin
        next_s.holdCnt[k] = s.holdCnt[k] - 10'h001;
      end
    end
    if (trip) begin
      next_s.holdCnt[tripCause] = 10'(HOLD_TICKS);
      next_s.state = ar_pkg::LOCK;
      next_s.tripDone = 1'b0;
      next_s.shot = 3'h0;
    end

    // Outputs are derived from the next state so they come from flip-flops.
    for (int k = 0; k < 5; k++) begin
      next_s.ind.finalTrip[k] = next_s.holdCnt[k] != 10'h000;
    end
    next_s.ind.running = next_s.state == ar_pkg::DEAD;
    next_s.ind.shotActive = 5'h00;
    if (next_s.state inside {ar_pkg::OPEN, ar_pkg::DEAD, ar_pkg::CLOSE, ar_pkg::DISCR}
        || (next_s.state == ar_pkg::RECLAIM && !next_s.manual)) begin
      next_s.ind.shotActive = 5'h01 << next_s.shot;
    end
    next_s.cmd.openCmd = cbClosed && (next_s.state == ar_pkg::OPEN
        || (next_s.state == ar_pkg::LOCK && !next_s.tripDone));
    next_s.cmd.closeCmd = next_s.state == ar_pkg::CLOSE && !cbClosed
        && !(s.ctrl[`CTRL_CLOSE_BLOCK_BIT] && rcb);
  end

  // Single state register; reset loads constants only.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s <= '0;
      s.ctrl <= `RST_CTRL;
      s.shotEn <= `RST_SHOT_EN;
      s.reclaim <= `RST_SETTING;
      s.state <= ar_pkg::IDLE;
    end else begin
      s <= next_s;
    end
  end

  // Zero-wait slave that always answers OKAY.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s.rdata;
  assign breakerCmd = s.cmd;
  assign indication = s.ind;
endmodule
`default_nettype wire

// ---- hdl/pin_sync.sv ----
// Two-stage synchroniser for a group of pin inputs.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [W-1:0] pinIn,
  output logic [W-1:0] pinOut
);
  typedef struct packed {
    logic [W-1:0] first;
    logic [W-1:0] second;
  } sync_state_t;
  sync_state_t s;
  sync_state_t next_s;

  // The first stage feeds only the second stage.
  always_comb begin
    next_s.first = pinIn;
    next_s.second = s.first;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign pinOut = s.second;
endmodule
`default_nettype wire

// ---- hdl/tick_divider.sv ----
// Divider producing the one-cycle timer tick.
`timescale 1ns/1ps
`default_nettype none
module tick_divider #(
  parameter int CYCLES = 10000
) (
  input wire logic clock,
  input wire logic rst,
  output logic tick
);
  typedef struct packed {
    logic [31:0] count;
    logic tick;
  } div_state_t;
  div_state_t s;
  div_state_t next_s;

  // Count cycles and pulse once per period.
  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    if (s.count >= 32'(CYCLES - 1)) begin
      next_s.count = '0;
      next_s.tick = 1'b1;
    end else begin
      next_s.count = s.count + 32'h0000_0001;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick = s.tick;
endmodule
`default_nettype wire

// ---- pkg/ar_consts.svh ----
// Register offsets, field positions, reset values and timing figures of the reclose sequencer.
`ifndef AR_CONSTS_SVH
`define AR_CONSTS_SVH
`define CLOCK_PERIOD_NS 100
`define TICK_PERIOD_NS 1000000
`define FINAL_TRIP_HOLD_NS 500000000
`define OFS_CTRL 32'h0000_0000
`define OFS_SHOT_EN 32'h0000_0004
`define OFS_RECLAIM 32'h0000_000C
`define OFS_STATUS 32'h0000_0010
`define OFS_START_BASE 32'h0000_0020
`define OFS_DEAD_BASE 32'h0000_0040
`define OFS_DISCR_BASE 32'h0000_0060
`define CTRL_ENABLE_BIT 0
`define CTRL_CLOSE_BLOCK_BIT 1
`define CTRL_SHOT_BLOCK_LSB 2
`define STAT_STATE_LSB 0
`define STAT_SHOT_ACTIVE_LSB 3
`define STAT_RUNNING_BIT 8
`define STAT_FINAL_LSB 9
`define STAT_OPEN_BIT 14
`define STAT_CLOSE_BIT 15
`define STAT_SHOT_LSB 16
`define STAT_MANUAL_BIT 19
`define RST_CTRL 7'h00
`define RST_SHOT_EN 20'h0_0000
`define RST_SETTING 16'h0000
`endif

// ---- pkg/ar_pkg.sv ----
// Types shared by the reclose sequencer files.
`default_nettype none
package ar_pkg;
  typedef enum logic [2:0] {
    IDLE = 3'h0,
    OPEN = 3'h1,
    DEAD = 3'h3,
    CLOSE = 3'h2,
    DISCR = 3'h6,
    RECLAIM = 3'h7,
    LOCK = 3'h5
  } seq_state_t;

  typedef struct packed {
    logic [4:0] shotActive;
    logic running;
    logic [4:0] finalTrip;
  } indication_t;

  typedef struct packed {
    logic openCmd;
    logic closeCmd;
  } breaker_cmd_t;
endpackage
`default_nettype wire

// ---- tb/auto_reclose_sequencer_asserts.sv ----
// Checker for the breaker command and indication outputs.
`timescale 1ns/1ps
`default_nettype none
module auto_reclose_sequencer_asserts #(
  parameter int TICK_CYCLES = 10
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic breakerClosed,
  input wire ar_pkg::breaker_cmd_t breakerCmd,
  input wire ar_pkg::indication_t indication
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  localparam int HOLD = 500 * TICK_CYCLES;
  int held;
  // Length of the current final-trip pulse in clocks; tick phase allows one tick of slack.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) held <= 0;
    else if (|indication.finalTrip) held <= held + 1;
    else held <= 0;
  end
  cmd_exclusive_a: assert property (!(breakerCmd.openCmd && breakerCmd.closeCmd))
    else $error("open and close commands together");
  hold_limit_a: assert property (held <= HOLD + TICK_CYCLES)
    else $error("final trip held too long");
  hold_length_a: assert property (
    $fell(|indication.finalTrip) |-> held >= HOLD - TICK_CYCLES)
    else $error("final trip cleared too soon");
  final_onehot_a: assert property ($onehot0(indication.finalTrip))
    else $error("more than one final trip");
  shot_onehot_a: assert property ($onehot0(indication.shotActive))
    else $error("more than one shot active");
  dead_quiet_a: assert property (
    indication.running |-> !breakerCmd.openCmd && !breakerCmd.closeCmd)
    else $error("command during dead time");
  run_open_a: assert property ($rose(indication.running) |-> !breakerClosed)
    else $error("dead time with breaker closed");
  open_release_a: assert property (
    breakerCmd.openCmd && !breakerClosed |-> ##[1:4] !breakerCmd.openCmd)
    else $error("open command not released");
  close_release_a: assert property (
    breakerCmd.closeCmd && breakerClosed |-> ##[1:4] !breakerCmd.closeCmd)
    else $error("close command not released");
  crit_accept_a: assert property (
    $rose(indication.finalTrip[4]) |-> $past(indication.running) || $past(|indication.shotActive))
    else $error("critical trip outside a sequence");
  final_no_close_a: assert property (|indication.finalTrip |-> !breakerCmd.closeCmd)
    else $error("close command during final trip");
  cover property ($rose(indication.finalTrip[4]));
  cover property ($rose(indication.running));
  cover property ($fell(|indication.shotActive));
endmodule
bind auto_reclose_sequencer auto_reclose_sequencer_asserts #(.TICK_CYCLES(TICK_CYCLES)) i_chk (
  .clock(clock), .rst(rst), .breakerClosed(breakerClosed), .breakerCmd(breakerCmd),
  .indication(indication));
`default_nettype wire

// ---- tb/auto_reclose_sequencer_tb_top.sv ----
// Self-checking bench for the reclose sequencer.
`timescale 1ns/1ps
`default_nettype none
`include "ar_consts.svh"
module auto_reclose_sequencer_tb_top;
  logic clock, rst, hsel, hwrite, hready, hreadyout, hresp, criticalRequest, breakerClosed;
  logic recloseBlock, manualClose;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans;
  logic [3:0] requestLine;
  logic [4:0] shotBlock;
  logic [7:0] lag;
  ar_pkg::breaker_cmd_t breakerCmd;
  ar_pkg::indication_t indication;
  int n, n_mismatch, n_tests;
  assign hready = hreadyout;
  auto_reclose_sequencer #(.TICK_CYCLES(10)) i_dut (
    .clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .requestLine(requestLine), .criticalRequest(criticalRequest),
    .breakerClosed(breakerClosed), .shotBlock(shotBlock), .recloseBlock(recloseBlock),
    .breakerCmd(breakerCmd), .indication(indication));
  breaker_model i_cb (
    .clock(clock), .rst(rst), .openCmd(breakerCmd.openCmd), .closeCmd(breakerCmd.closeCmd),
    .manualClose(manualClose), .lag(lag), .breakerClosed(breakerClosed));
  // Clock of 100 ns period.
  always #50 clock = ~clock;
  task automatic summarize;
    $display("Checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_tests++;
    if (s !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Waits for the slave's ready; a stuck bus ends the run.
  task automatic hwait;
    int k;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (hready !== 1'b1 && k < 20);
    if (k >= 20) begin
      n_mismatch++;
      summarize();
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    hwait();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    hwait();
    q = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input string nm, input logic [31:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk(nm, e, q);
  endtask
  // Reset rises in the current step, so the first one covers time zero with no unknowns.
  task automatic reset;
    rst <= 1'b1;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
  endtask
  // Settings in ticks: start 2, dead 3, discrimination 4.
  task automatic cfg(input logic [31:0] ctl, input logic [31:0] en, input logic [31:0] rec);
    for (int i = 0; i < 20; i++) begin
      if (i < 4) wr(`OFS_START_BASE + 32'(4 * i), 32'h0000_0002);
      if (i < 5) wr(`OFS_DEAD_BASE + 32'(4 * i), 32'h0000_0003);
      wr(`OFS_DISCR_BASE + 32'(4 * i), 32'h0000_0004);
    end
    wr(`OFS_RECLAIM, rec);
    wr(`OFS_SHOT_EN, en);
    wr(`OFS_CTRL, ctl);
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: return breakerCmd.openCmd;
      1: return breakerCmd.closeCmd;
      2: return indication.running;
      3: return |indication.finalTrip;
      4: return |indication.shotActive;
      default: return breakerClosed;
    endcase
  endfunction
  // Bounded wait for an output level; n returns the clocks taken.
  task automatic waitv(input int s, input logic v);
    n = 0;
    while (pick(s) !== v) begin
      @(posedge clock);
      n++;
      if (n > 6000) begin
        chk("wait", 32'(v), 32'(pick(s)));
        summarize();
      end
    end
  endtask
  initial begin
    {clock, rst, hsel, hwrite, criticalRequest, recloseBlock, manualClose} = 7'h00;
    {haddr, hwdata, htrans, requestLine, shotBlock} = '0;
    lag = 8'h05;
    n_mismatch = 0;
    n_tests = 0;
    reset();
    rd("ctrl", `OFS_CTRL, 32'h0000_0000);
    wr(`OFS_START_BASE + 32'h0000_000C, 32'h0000_1234);
    rd("start4", `OFS_START_BASE + 32'h0000_000C, 32'h0000_1234);
    wr(32'h0000_0008, 32'h0000_FFFF);
    rd("unmapped", 32'h0000_0008, 32'h0000_0000);
    chk("hresp", 32'h0000_0000, 32'(hresp));
    cfg(32'h0000_000B, 32'h0000_0007, 32'h0000_0005);
    criticalRequest <= 1'b1;
    repeat (40) @(posedge clock);
    chk("idle critical", 32'h0000_0000, 32'(indication.finalTrip));
    criticalRequest <= 1'b0;
    recloseBlock <= 1'b1;
    shotBlock <= 5'h02;
    requestLine <= 4'h1;
    waitv(0, 1'b1);
    chk("first shot", 32'h0000_0001, 32'(indication.shotActive));
    waitv(2, 1'b1);
    chk("open released", 32'h0000_0000, 32'(breakerCmd.openCmd));
    repeat (60) @(posedge clock);
    chk("close withheld", 32'h0000_0000, 32'(breakerCmd.closeCmd));
    recloseBlock <= 1'b0;
    waitv(1, 1'b1);
    chk("close prompt", 32'h0000_0001, 32'(n <= 6));
    waitv(1, 1'b0);
    waitv(0, 1'b1);
    chk("skip blocked", 32'h0000_0004, 32'(indication.shotActive));
    requestLine <= 4'h0;
    waitv(2, 1'b1);
    waitv(2, 1'b0);
    chk("dead length", 32'h0000_0001, 32'(n >= 20 && n <= 42));
    chk("close at dead end", 32'h0000_0001, 32'(breakerCmd.closeCmd));
    waitv(1, 1'b0);
    waitv(4, 1'b0);
    chk("reclaim", 32'h0000_0001, 32'(n >= 70 && n <= 120));
    reset();
    lag <= 8'h14;
    cfg(32'h0000_0001, 32'h0000_0080, 32'h0000_0014);
    wr(`OFS_START_BASE + 32'h0000_0004, 32'h0000_0028);
    wr(`OFS_DISCR_BASE + 32'h0000_0014, 32'h0000_0002);
    requestLine <= 4'h2;
    waitv(0, 1'b1);
    chk("later start", 32'h0000_0001, 32'(n >= 15 && n <= 40));
    chk("shot three", 32'h0000_0004, 32'(indication.shotActive));
    waitv(2, 1'b1);
    criticalRequest <= 1'b1;
    waitv(3, 1'b1);
    chk("critical", 32'h0000_0010, 32'(indication.finalTrip));
    waitv(3, 1'b0);
    chk("trip length", 32'h0000_0001, 32'(n >= 4985 && n <= 5015));
    rd("locked", `OFS_STATUS, 32'(ar_pkg::LOCK));
    {criticalRequest, requestLine} <= 5'h00;
    manualClose <= 1'b1;
    @(posedge clock);
    manualClose <= 1'b0;
    repeat (5) @(posedge clock);
    requestLine <= 4'h1;
    repeat (150) @(posedge clock);
    chk("manual reclaim", 32'h0000_0000, 32'({breakerCmd, indication.finalTrip}));
    requestLine <= 4'h0;
    reset();
    lag <= 8'h05;
    cfg(32'h0000_0001, 32'h0000_0041, 32'h0000_0005);
    // Line two starts at shot two, so its delay equals line one's and both expire together.
    wr(`OFS_DISCR_BASE + 32'h0000_0004, 32'h0000_0002);
    requestLine <= 4'h3;
    waitv(0, 1'b1);
    chk("priority", 32'h0000_0001, 32'(indication.shotActive));
    waitv(3, 1'b1);
    chk("line one trip", 32'h0000_0001, 32'(indication.finalTrip));
    repeat (2) @(posedge clock);
    chk("trip opens", 32'h0000_0001, 32'(breakerCmd.openCmd));
    summarize();
  end
endmodule
`default_nettype wire

// ---- tb/breaker_model.sv ----
// Behavioural circuit breaker with a settable mechanism lag and a manual close.
`timescale 1ns/1ps
`default_nettype none
module breaker_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic openCmd,
  input wire logic closeCmd,
  input wire logic manualClose,
  input wire logic [7:0] lag,
  output logic breakerClosed
);
  logic [7:0] cnt;
  // Contacts move only after the lag, so a command released early does nothing.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      breakerClosed <= 1'b1;
      cnt <= 8'h00;
    end else if (manualClose) begin
      breakerClosed <= 1'b1;
    end else if ((openCmd && breakerClosed) || (closeCmd && !breakerClosed)) begin
      cnt <= cnt + 8'h01;
      if (cnt >= lag) begin
        breakerClosed <= !breakerClosed;
        cnt <= 8'h00;
      end
    end else begin
      cnt <= 8'h00;
    end
  end
endmodule
`default_nettype wire
